// ### hw/adc_converter_end.sv
// Converter-side ADC control: link decoder, mux and sample-hold sequencing, frame-shadowed results
// What this block does
// [RL1] Every conversion yields one 12-bit result
// [RL2] Mux picks exactly one of 32 inputs
// [RL3] Paired: both holds capture together, convert sequentially
// [RL4] Channel zero only for differential LED current
// [RL5] Channels one to seven are unity-gain pins
// [RL6] Channels 8-31 internal; channel 28 unused
// [RL7] Up to 63 hardware-timed samples per frame
// [RL8] Controller sends schedule and channel commands serially
// [RL9] Shadow buffer refreshed per frame, then held
// [RL10] Controller places samples at fixed sequence positions
// [RL11] 5-bit select equals channel number
// [RL12] Channel-zero gain selectable 24, 12 or 9
`timescale 1ns/100ps
module adc_converter_end #(
  parameter int SAMPLES = adc_link_pkg::MAX_SAMPLES
) (
  // Clock and reset
  input  wire logic                            hclk,
  input  wire logic                            hresetn,
  // Link to the scheduler
  adc_link_if.converter                        link,
  // Analog core
  output logic [adc_link_pkg::CH_W-1:0]        mux_sel,
  output logic                                 mux_diff,
  output logic                                 sh_capture,
  output logic                                 conv_unit,
  output logic                                 conv_start,
  input  wire logic                            conv_done,
  input  wire logic [adc_link_pkg::RES_W-1:0]  conv_data,
  // Configuration
  input  wire logic [1:0]                      gain_cfg,
  output logic [1:0]                           amp_gain
);
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_CONV_A = 3'b010,
    ST_CONV_B = 3'b100
  } conv_state_t;

  localparam int RW = adc_link_pkg::RES_W;

  conv_state_t                            state;
  logic [adc_link_pkg::CMD_W-1:0]         rx_sr;
  logic                                   rx_sel_d;
  logic                                   rx_done;
  logic [1:0]                             cmd_type;
  logic                                   cmd_pair;
  logic [adc_link_pkg::CH_W-1:0]          cmd_cha;
  logic [adc_link_pkg::CH_W-1:0]          cmd_chb;
  logic [adc_link_pkg::SLOT_W-1:0]        cmd_slot;
  logic [adc_link_pkg::SLOT_W-1:0]        cur_slot;
  logic                                   cur_pair;
  logic [adc_link_pkg::CH_W-1:0]          cur_chb;
  logic                                   cha_unused;
  logic [RW-1:0]                          res_a;
  logic                                   store;
  logic [adc_link_pkg::REPLY_W-1:0]       store_word;
  logic [adc_link_pkg::REPLY_W-1:0]       work   [SAMPLES];
  logic [adc_link_pkg::REPLY_W-1:0]       shadow [SAMPLES];
  logic [adc_link_pkg::REPLY_W-1:0]       tx_sr;
  logic [5:0]                             tx_cnt;

  // Link receive: a command ends when its select drops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_sr    <= '0;
      rx_sel_d <= 1'b0;
    end else begin
      rx_sel_d <= link.cmd_sel;
      if (link.cmd_sel) begin
        rx_sr <= {rx_sr[adc_link_pkg::CMD_W-2:0], link.cmd_bit}; // [RL8]
      end
    end
  end

  assign rx_done  = rx_sel_d & ~link.cmd_sel;
  assign cmd_type = rx_sr[adc_link_pkg::F_TYPE_LSB +: 2];
  assign cmd_pair = rx_sr[adc_link_pkg::F_PAIR];
  assign cmd_cha  = rx_sr[adc_link_pkg::F_CHA_LSB +: adc_link_pkg::CH_W];
  assign cmd_chb  = rx_sr[adc_link_pkg::F_CHB_LSB +: adc_link_pkg::CH_W];
  assign cmd_slot = rx_sr[adc_link_pkg::F_SLOT_LSB +: adc_link_pkg::SLOT_W];

  // Conversion sequencing; a sample arriving while busy is dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state      <= ST_IDLE;
      mux_sel    <= adc_link_pkg::CH_LED_SENSE;
      mux_diff   <= 1'b0;
      sh_capture <= 1'b0;
      conv_unit  <= 1'b0;
      conv_start <= 1'b0;
      cur_slot   <= '0;
      cur_pair   <= 1'b0;
      cur_chb    <= '0;
      cha_unused <= 1'b0;
      res_a      <= '0;
      store      <= 1'b0;
      store_word <= '0;
    end else begin
      sh_capture <= 1'b0;
      conv_start <= 1'b0;
      store      <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (rx_done && cmd_type == adc_link_pkg::CMD_SAMPLE
              && int'(cmd_slot) < SAMPLES) begin // [RL7]
            mux_sel    <= cmd_cha; // [RL2] [RL11]
            mux_diff   <= (cmd_cha == adc_link_pkg::CH_LED_SENSE); // [RL4] [RL5]
            cha_unused <= (cmd_cha == adc_link_pkg::CH_UNUSED); // [RL6]
            sh_capture <= 1'b1; // [RL3]
            conv_unit  <= 1'b0;
            conv_start <= 1'b1;
            cur_slot   <= cmd_slot;
            cur_pair   <= cmd_pair;
            cur_chb    <= cmd_chb;
            state      <= ST_CONV_A;
          end
        end
        ST_CONV_A: begin
          if (conv_done) begin
            res_a <= cha_unused ? '0 : conv_data; // [RL1] [RL6]
            if (cur_pair) begin
              // Second hold already captured; only the converter is reused
              mux_sel    <= cur_chb; // [RL3]
              mux_diff   <= (cur_chb == adc_link_pkg::CH_LED_SENSE); // [RL4]
              cha_unused <= (cur_chb == adc_link_pkg::CH_UNUSED);
              conv_unit  <= 1'b1;
              conv_start <= 1'b1;
              state      <= ST_CONV_B;
            end else begin
              store      <= 1'b1;
              store_word <= {{RW{1'b0}}, (cha_unused ? {RW{1'b0}} : conv_data)}; // [RL1]
              state      <= ST_IDLE;
            end
          end
        end
        ST_CONV_B: begin
          if (conv_done) begin
            store      <= 1'b1;
            store_word <= {(cha_unused ? {RW{1'b0}} : conv_data), res_a}; // [RL3]
            state      <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Working buffer fills during the frame; frame command moves it to the shadow
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < SAMPLES; i++) begin
        work[i]   <= '0;
        shadow[i] <= '0;
      end
    end else begin
      if (rx_done && cmd_type == adc_link_pkg::CMD_FRAME) begin
        for (int i = 0; i < SAMPLES; i++) begin
          shadow[i] <= work[i]; // [RL9]
          work[i]   <= '0;
        end
      end
      // A store in the swap cycle lands in the new frame's buffer
      if (store) begin
        work[cur_slot] <= store_word; // [RL7]
      end
    end
  end

  // Shadow read-out: 24-bit reply, MSB first, while res_sel is high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_sr        <= '0;
      tx_cnt       <= '0;
      link.res_sel <= 1'b0;
      link.res_bit <= 1'b0;
    end else begin
      if (tx_cnt != 6'h00) begin
        link.res_sel <= 1'b1;
        link.res_bit <= tx_sr[adc_link_pkg::REPLY_W-1];
        tx_sr        <= {tx_sr[adc_link_pkg::REPLY_W-2:0], 1'b0};
        tx_cnt       <= tx_cnt - 6'h01;
      end else begin
        link.res_sel <= 1'b0;
        link.res_bit <= 1'b0;
        if (rx_done && cmd_type == adc_link_pkg::CMD_READ) begin
          tx_sr  <= (int'(cmd_slot) < SAMPLES) ? shadow[cmd_slot] : '0; // [RL9]
          tx_cnt <= 6'(adc_link_pkg::REPLY_W);
        end
      end
    end
  end

  // Gain code 3 is not a valid setting and falls back to the highest gain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      amp_gain <= adc_link_pkg::GAIN_24X;
    end else begin
      case (gain_cfg)
        adc_link_pkg::GAIN_12X: amp_gain <= adc_link_pkg::GAIN_12X; // [RL12]
        adc_link_pkg::GAIN_9X:  amp_gain <= adc_link_pkg::GAIN_9X;
        default:                amp_gain <= adc_link_pkg::GAIN_24X;
      endcase
    end
  end

  // Pin channels stay single-ended; only channel zero goes through the gain stage
endmodule

// ### hw/adc_link_if.sv
// Serial control link between the sample scheduler and the converter
`timescale 1ns/100ps
interface adc_link_if;
  logic cmd_sel;
  logic cmd_bit;
  logic res_sel;
  logic res_bit;
  modport converter (input cmd_sel, input cmd_bit, output res_sel, output res_bit);
  modport scheduler (output cmd_sel, output cmd_bit, input res_sel, input res_bit);
endinterface

// ### hw/adc_link_pkg.sv
// Shared constants for the frame-scheduled ADC link and both ends
package adc_link_pkg;
  localparam int RES_W       = 12;
  localparam int CH_W        = 5;
  localparam int SLOT_W      = 6;
  localparam int MAX_SAMPLES = 63;
  localparam int TIME_W      = 16;
  localparam int CMD_W       = 19;
  localparam int REPLY_W     = 2 * RES_W;
  localparam int SCHED_W     = 27;
  // Command word fields
  localparam int F_TYPE_LSB  = 17;
  localparam int F_PAIR      = 16;
  localparam int F_CHA_LSB   = 11;
  localparam int F_CHB_LSB   = 6;
  localparam int F_SLOT_LSB  = 0;
  localparam logic [1:0] CMD_FRAME  = 2'h0;
  localparam logic [1:0] CMD_SAMPLE = 2'h1;
  localparam logic [1:0] CMD_READ   = 2'h2;
  // Channel map
  localparam logic [4:0] CH_LED_SENSE = 5'h00;
  localparam logic [4:0] CH_EXT_LAST  = 5'h07;
  localparam logic [4:0] CH_UNUSED    = 5'h1C;
  // Channel-zero amplifier gain codes
  localparam logic [1:0] GAIN_24X = 2'h0;
  localparam logic [1:0] GAIN_12X = 2'h1;
  localparam logic [1:0] GAIN_9X  = 2'h2;
  // Schedule entry fields
  localparam int S_TIME_LSB = 0;
  localparam int S_CHA_LSB  = 16;
  localparam int S_CHB_LSB  = 21;
  localparam int S_PAIR     = 26;
  // Controller register map (byte addresses)
  localparam logic [11:0] REG_CTRL    = 12'h000;
  localparam logic [11:0] REG_STATUS  = 12'h004;
  localparam logic [3:0]  SCHED_PAGE  = 4'h1;
  localparam logic [3:0]  RESULT_PAGE = 4'h2;
  localparam logic [6:0]  CTRL_RESET  = 7'h00;
endpackage

// ### hw/adc_scheduler_end.sv
// Controller-side ADC scheduler: AHB-Lite registers, frame timer, link commands
`timescale 1ns/100ps
module adc_scheduler_end #(
  parameter int SAMPLES = adc_link_pkg::MAX_SAMPLES
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Display sequencer
  input  wire logic        seq_frame_start,
  // Link to the converter
  adc_link_if.scheduler    link
);
  localparam int TW = adc_link_pkg::TIME_W;

  logic [adc_link_pkg::SCHED_W-1:0] sched [SAMPLES];
  logic                             en;
  logic [5:0]                       num;
  logic [TW-1:0]                    timer;
  logic [5:0]                       idx;
  logic [15:0]                      frame_cnt;
  logic                             frame_pend;
  logic                             rd_pend;
  logic [5:0]                       rd_slot;
  logic                             a_wr;
  logic [11:0]                      a_addr;
  logic                             a_rd_res;
  logic [adc_link_pkg::CMD_W-1:0]   tx_sr;
  logic [4:0]                       tx_cnt;
  logic                             sample_due;
  logic [adc_link_pkg::SCHED_W-1:0] ent;
  logic [adc_link_pkg::REPLY_W-1:0] rx_sr;
  logic                             rx_sel_d;
  logic                             rx_done;
  logic                             take;

  assign take = hsel & hready & htrans[1];
  assign ent  = sched[idx];
  assign sample_due = en && !frame_pend && idx < num && int'(idx) < SAMPLES
                      && timer >= ent[adc_link_pkg::S_TIME_LSB +: TW]; // [RL10]
  assign rx_done = rx_sel_d & ~link.res_sel;

  // Bus slave: registers answer with no wait; result reads wait for the link reply
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_wr      <= 1'b0;
      a_addr    <= '0;
      a_rd_res  <= 1'b0;
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      en        <= adc_link_pkg::CTRL_RESET[0];
      num       <= adc_link_pkg::CTRL_RESET[6:1];
      rd_pend   <= 1'b0;
      rd_slot   <= '0;
    end else begin
      a_wr <= take & hwrite;
      if (take) begin
        a_addr <= haddr;
      end
      if (a_wr) begin
        if (a_addr == adc_link_pkg::REG_CTRL) begin
          en  <= hwdata[0];
          num <= hwdata[6:1];
        end else if (a_addr[11:8] == adc_link_pkg::SCHED_PAGE && int'(a_addr[7:2]) < SAMPLES) begin
          sched[a_addr[7:2]] <= hwdata[adc_link_pkg::SCHED_W-1:0];
        end
      end
      if (rd_pend && tx_cnt == 5'h00 && !frame_pend && !sample_due) begin
        rd_pend <= 1'b0;
      end
      if (take && !hwrite) begin
        case (haddr[11:8])
          4'h0: begin
            if (haddr == adc_link_pkg::REG_CTRL) begin
              hrdata <= {25'h0000000, num, en};
            end else if (haddr == adc_link_pkg::REG_STATUS) begin
              hrdata <= {frame_cnt, 2'h0, idx, 7'h00, (tx_cnt != 5'h00)};
            end else begin
              hrdata <= '0;
            end
          end
          adc_link_pkg::SCHED_PAGE: begin
            hrdata <= (int'(haddr[7:2]) < SAMPLES) ? {5'h00, sched[haddr[7:2]]} : '0;
          end
          adc_link_pkg::RESULT_PAGE: begin
            hreadyout <= 1'b0;
            a_rd_res  <= 1'b1;
            rd_pend   <= 1'b1;
            rd_slot   <= haddr[7:2];
          end
          default: begin
            hrdata <= '0;
          end
        endcase
      end else if (a_rd_res && rx_done) begin
        hrdata    <= {8'h00, rx_sr};
        hreadyout <= 1'b1;
        a_rd_res  <= 1'b0;
      end
    end
  end

  // Frame timer and sample pointer follow the sequencer's frame pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer      <= '0;
      frame_cnt  <= '0;
      frame_pend <= 1'b0;
    end else begin
      if (seq_frame_start) begin
        timer      <= '0;
        frame_cnt  <= frame_cnt + 16'h0001;
        frame_pend <= 1'b1; // Set wins over the clear below
      end else begin
        if (timer != {TW{1'b1}}) begin
          timer <= timer + 1'b1;
        end
        if (frame_pend && tx_cnt == 5'h00) begin
          frame_pend <= 1'b0;
        end
      end
    end
  end

  // Command transmitter: frame swap first, then due samples, then reads
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_sr        <= '0;
      tx_cnt       <= '0;
      idx          <= '0;
      link.cmd_sel <= 1'b0;
      link.cmd_bit <= 1'b0;
    end else begin
      if (tx_cnt != 5'h00) begin
        link.cmd_sel <= 1'b1;
        link.cmd_bit <= tx_sr[adc_link_pkg::CMD_W-1];
        tx_sr        <= {tx_sr[adc_link_pkg::CMD_W-2:0], 1'b0};
        tx_cnt       <= tx_cnt - 5'h01;
      end else begin
        link.cmd_sel <= 1'b0;
        link.cmd_bit <= 1'b0;
        if (frame_pend) begin
          tx_sr  <= {adc_link_pkg::CMD_FRAME, 17'h00000}; // [RL9]
          tx_cnt <= 5'(adc_link_pkg::CMD_W);
          idx    <= '0;
        end else if (sample_due) begin
          tx_sr  <= {adc_link_pkg::CMD_SAMPLE, ent[adc_link_pkg::S_PAIR],
                     ent[adc_link_pkg::S_CHA_LSB +: adc_link_pkg::CH_W],
                     ent[adc_link_pkg::S_CHB_LSB +: adc_link_pkg::CH_W], idx}; // [RL7] [RL8]
          tx_cnt <= 5'(adc_link_pkg::CMD_W);
          idx    <= idx + 6'h01;
        end else if (rd_pend) begin
          tx_sr  <= {adc_link_pkg::CMD_READ, 11'h000, rd_slot};
          tx_cnt <= 5'(adc_link_pkg::CMD_W);
        end
      end
    end
  end

  // Reply receiver
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_sr    <= '0;
      rx_sel_d <= 1'b0;
    end else begin
      rx_sel_d <= link.res_sel;
      if (link.res_sel) begin
        rx_sr <= {rx_sr[adc_link_pkg::REPLY_W-2:0], link.res_bit};
      end
    end
  end
endmodule

// ### tb/adc_frame_sample_control_test.sv
// Bench joining scheduler and converter ends, with a simple conversion model
`timescale 1ns/100ps
module adc_frame_sample_control_test;
  typedef struct packed {
    logic [15:0] start;
    logic [4:0]  ch_a;
    logic [4:0]  ch_b;
    logic        pair;
    logic [31:0] want;
  } row_t;
  localparam int   LIMIT = 20000;
  localparam int   NROW  = 4;
  // Model result is {unit, bias, 5'h0A, channel}; unpaired B and channel 28 read 0
  localparam row_t ROWS [NROW] = '{
    '{16'h0010, 5'h00, 5'h00, 1'b0, 32'h00000140},
    '{16'h00C8, 5'h07, 5'h0C, 1'b1, 32'h0094C147},
    '{16'h0190, 5'h1C, 5'h00, 1'b0, 32'h00000000},
    '{16'h0258, 5'h1F, 5'h1C, 1'b1, 32'h0000015F}
  };
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, seq_frame_start;
  logic [11:0] haddr, conv_data;
  logic [1:0]  htrans, gain_cfg, amp_gain;
  logic [2:0]  hsize, cv_cnt;
  logic [31:0] hwdata, hrdata, got;
  logic [4:0]  mux_sel, cv_ch;
  logic        mux_diff, sh_capture, conv_unit, conv_start, conv_done, cv_u, bias;
  int          n_errors, total_checks, cycles;

  adc_link_if adc_link_if_i ();
  adc_scheduler_end adc_scheduler_end_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .seq_frame_start(seq_frame_start), .link(adc_link_if_i));
  adc_converter_end adc_converter_end_i (.hclk(hclk), .hresetn(hresetn), .link(adc_link_if_i),
    .mux_sel(mux_sel), .mux_diff(mux_diff), .sh_capture(sh_capture), .conv_unit(conv_unit),
    .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data), .gain_cfg(gain_cfg),
    .amp_gain(amp_gain));
  adc_link_checker adc_link_checker_i (.hclk(hclk), .hresetn(hresetn), .cmd_sel(adc_link_if_i.cmd_sel),
    .cmd_bit(adc_link_if_i.cmd_bit), .res_sel(adc_link_if_i.res_sel), .res_bit(adc_link_if_i.res_bit));

  task automatic check_word(input logic [31:0] g, input logic [31:0] e, input string what);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One single-word transfer; waits on hreadyout, never on a fixed count
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    got = hrdata;
  endtask

  task automatic frame(input int wait_cycles);
    seq_frame_start <= 1'b1;
    @(posedge hclk);
    seq_frame_start <= 1'b0;
    repeat (wait_cycles) @(posedge hclk);
  endtask

  function automatic logic [11:0] model(input logic [4:0] ch, input logic u);
    return {u, bias, 5'h0A, ch};
  endfunction

  // Conversion model: four cycles from start to done
  always @(posedge hclk) begin
    conv_done <= 1'b0;
    if (conv_start === 1'b1) begin
      cv_ch  <= mux_sel;
      cv_u   <= conv_unit;
      cv_cnt <= 3'h4;
      check_word({31'h0, mux_diff}, {31'h0, mux_sel == 5'h00}, "differential select");
      check_word({31'h0, sh_capture}, {31'h0, ~conv_unit}, "hold capture");
    end else if (cv_cnt != 3'h0) begin
      cv_cnt <= cv_cnt - 3'h1;
      if (cv_cnt == 3'h1) begin
        conv_done <= 1'b1;
        conv_data <= model(cv_ch, cv_u);
      end
    end
  end

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      $display("wrong value at %0t: run did not finish", $time);
      report_and_stop();
    end
  end

  initial begin
    {hresetn, hsel, hwrite, seq_frame_start, conv_done, bias, cv_u} = 7'h00;
    {haddr, conv_data, htrans, gain_cfg, cv_cnt, cv_ch} = 36'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    n_errors = 0;
    total_checks = 0;
    cycles = 0;
    repeat (2) @(posedge hclk);
    check_word({23'h0, adc_link_if_i.cmd_sel, adc_link_if_i.res_sel, mux_sel, hresp, hreadyout}, 32'h1, "reset state");
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, adc_link_pkg::REG_CTRL, 32'h0);
    check_word(got, {25'h0, adc_link_pkg::CTRL_RESET}, "control reset value");
    ahb(1'b1, 12'h0F0, 32'hFFFFFFFF);
    ahb(1'b0, 12'h0F0, 32'h0);
    check_word(got, 32'h0, "unmapped read");
    for (int i = 0; i < 4; i++) begin
      gain_cfg <= 2'(i);
      repeat (3) @(posedge hclk);
      check_word({30'h0, amp_gain}, (i == 3) ? 32'h0 : 32'(i), "gain code");
    end
    for (int i = 0; i < NROW; i++) begin
      ahb(1'b1, {adc_link_pkg::SCHED_PAGE, 8'(i * 4)}, {5'h0, ROWS[i].pair, ROWS[i].ch_b, ROWS[i].ch_a, ROWS[i].start});
    end
    ahb(1'b1, adc_link_pkg::REG_CTRL, 32'h9);
    frame(900);
    frame(40);
    bias <= 1'b1;
    for (int i = 0; i < NROW; i++) begin
      ahb(1'b0, {adc_link_pkg::RESULT_PAGE, 8'(i * 4)}, 32'h0);
      check_word(got, ROWS[i].want, "result slot");
    end
    ahb(1'b0, {adc_link_pkg::RESULT_PAGE, 8'h14}, 32'h0);
    check_word(got, 32'h0, "unused slot");
    repeat (900) @(posedge hclk);
    ahb(1'b0, {adc_link_pkg::RESULT_PAGE, 8'h04}, 32'h0);
    check_word(got, ROWS[1].want, "shadow held in frame");
    frame(40);
    ahb(1'b0, {adc_link_pkg::RESULT_PAGE, 8'h04}, 32'h0);
    check_word(got, 32'h00D4C547, "shadow after frame");
    for (int i = 0; i < 63; i++) begin
      ahb(1'b1, {adc_link_pkg::SCHED_PAGE, 8'(i * 4)}, {16'h0, 16'(i * 40 + 16)} | (32'(i % 32) << 16));
    end
    ahb(1'b1, adc_link_pkg::REG_CTRL, 32'h7F);
    frame(2700);
    frame(40);
    ahb(1'b0, {adc_link_pkg::RESULT_PAGE, 8'hF8}, 32'h0);
    check_word(got, 32'h0000055E, "last of 63 slots");
    ahb(1'b0, {adc_link_pkg::RESULT_PAGE, 8'h70}, 32'h0);
    check_word(got, 32'h0, "unused channel");
    ahb(1'b0, {adc_link_pkg::RESULT_PAGE, 8'h00}, 32'h0);
    check_word(got, 32'h00000540, "first slot");
    // Reset in mid-run, while samples of the next frame are still in flight
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    check_word({23'h0, adc_link_if_i.cmd_sel, adc_link_if_i.res_sel, mux_sel, hresp, hreadyout}, 32'h1, "mid-run reset");
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, adc_link_pkg::REG_CTRL, 32'h0);
    check_word(got, {25'h0, adc_link_pkg::CTRL_RESET}, "control after reset");
    report_and_stop();
  end
endmodule

// ### tb/adc_link_checker.sv
// Protocol checker for the serial link between scheduler and converter
`timescale 1ns/100ps
module adc_link_checker #(
  parameter int SAMPLES = adc_link_pkg::MAX_SAMPLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link lines
  input wire logic cmd_sel,
  input wire logic cmd_bit,
  input wire logic res_sel,
  input wire logic res_bit
);
  logic [4:0]  cmd_cnt;
  logic [4:0]  res_cnt;
  logic [18:0] cmd_word;
  logic [6:0]  smp_cnt;
  logic        read_owed;
  wire  [1:0]  cmd_type = cmd_word[18:17];
  // Counters hold their count on the first idle sample, so no edge function sees reset values
  wire         cmd_end  = !cmd_sel && cmd_cnt != 5'h00;
  wire         res_end  = !res_sel && res_cnt != 5'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_cnt  <= 5'h00;
      cmd_word <= 19'h00000;
    end else if (cmd_sel) begin
      cmd_cnt  <= cmd_cnt + 5'h01;
      cmd_word <= {cmd_word[17:0], cmd_bit};
    end else begin
      cmd_cnt <= 5'h00;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_cnt <= 5'h00;
    end else begin
      res_cnt <= res_sel ? res_cnt + 5'h01 : 5'h00;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      smp_cnt <= 7'h00;
    end else if (cmd_end && cmd_type == adc_link_pkg::CMD_FRAME) begin
      smp_cnt <= 7'h00;
    end else if (cmd_end && cmd_type == adc_link_pkg::CMD_SAMPLE) begin
      smp_cnt <= smp_cnt + 7'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      read_owed <= 1'b0;
    end else if (cmd_end && cmd_type == adc_link_pkg::CMD_READ) begin
      read_owed <= 1'b1;
    end else if (res_sel) begin
      read_owed <= 1'b0;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  cmd_length_a: assert property (cmd_end |-> cmd_cnt == 5'h13)
    else $error("command not 19 bits long");
  reply_length_a: assert property (res_end |-> res_cnt == 5'h18)
    else $error("reply not two 12-bit results long");
  cmd_type_a: assert property (cmd_end |-> cmd_type != 2'h3)
    else $error("undefined command type");
  sample_slot_a: assert property (cmd_end && cmd_type == adc_link_pkg::CMD_SAMPLE |-> cmd_word[5:0] < SAMPLES)
    else $error("sample slot out of range");
  read_slot_a: assert property (cmd_end && cmd_type == adc_link_pkg::CMD_READ |-> cmd_word[5:0] < SAMPLES)
    else $error("read slot out of range");
  frame_budget_a: assert property (smp_cnt <= 7'h3F)
    else $error("more than 63 samples in a frame");
  reply_prompt_a: assert property (cmd_end && cmd_type == adc_link_pkg::CMD_READ |-> ##[1:3] $rose(res_sel))
    else $error("reply did not follow read command");
  reply_asked_a: assert property ($rose(res_sel) |-> read_owed)
    else $error("reply without read command");

  cover property (cmd_end && cmd_type == adc_link_pkg::CMD_FRAME);
  cover property (cmd_end && cmd_type == adc_link_pkg::CMD_SAMPLE && cmd_word[16]);
  cover property (res_end && read_owed == 1'b0);
endmodule
